// *** src/dee_pkg.sv ***
// constants and carriers for the data nonvolatile memory access controller
// assumes one system clock and a core that presents one register access per cycle
package dee_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map: sector and offsets of the four registers
  localparam logic [3:0] SECT_NVM      = 4'h1;
  localparam logic [7:0] OFS_CONTROL   = 8'h40;
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h41;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h42;
  localparam logic [7:0] OFS_DATA_PORT = 8'h43;

  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // nvm_control field positions
  localparam int B_TIME_SEL      = 7;
  localparam int B_WIPE_PERMIT   = 6;
  localparam int B_WIPE_TRIGGER  = 5;
  localparam int B_MODE          = 4;
  localparam int B_PROG_PERMIT   = 3;
  localparam int B_PROG_START    = 2;
  localparam int B_FETCH_PERMIT  = 1;
  localparam int B_FETCH_TRIGGER = 0;

  ////////////////////////////////////////////////////////////////////////////
  // cycle times in microseconds, per value of cycle_time_select
  localparam int ERASE_US_SEL0 = 3200;
  localparam int WRITE_US_SEL0 = 2200;
  localparam int ERASE_US_SEL1 = 3700;
  localparam int WRITE_US_SEL1 = 3000;
  localparam int US_PER_S      = 1000000;

  // read cycle length in system clocks
  localparam int READ_CLKS = 4;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum {ST_IDLE, ST_READ, ST_ERASE, ST_WRITE} dee_state_e;

  // one register access from the core
  typedef struct packed {
    logic       wr;        // write strobe
    logic       rd;        // read strobe
    logic       indirect;  // access made through a memory pointer
    logic [3:0] sector;    // sector number
    logic [7:0] addr;      // offset inside sector
    logic [7:0] wdata;     // write data
  } dee_req_s;

endpackage

// *** src/dee_ctrl.sv ***
// data nonvolatile memory access controller: registers, read/erase/write sequencing
// assumes core accesses are synchronous to i_clk_sys and i_sub_tick is a one-cycle
// pulse per period of the subsidiary low-speed clock, already synchronous
`timescale 1ns/1ns
`default_nettype none

module dee_ctrl #(
  parameter int MEM_BYTES  = 512,
  parameter int PAGE_BYTES = 16,
  parameter int SUB_HZ     = 32768
) (
  input  wire logic              i_clk_sys,  // system clock
  input  wire logic              i_rst_n,    // async reset, active low
  input  wire logic              i_sub_tick, // subsidiary clock tick
  input  wire dee_pkg::dee_req_s i_req,      // register access
  output logic [7:0]             o_rdata,    // read data, registered
  output logic                   o_busy      // a cycle is running
);

  localparam int ADDR_W = $clog2(MEM_BYTES);
  localparam int LOW_W  = $clog2(PAGE_BYTES);
  localparam int PAGE_W = ADDR_W - LOW_W;

  // subsidiary tick counts, rounded up
  localparam int TK_ERASE0 = (dee_pkg::ERASE_US_SEL0 * SUB_HZ + dee_pkg::US_PER_S - 1)
                             / dee_pkg::US_PER_S;
  localparam int TK_WRITE0 = (dee_pkg::WRITE_US_SEL0 * SUB_HZ + dee_pkg::US_PER_S - 1)
                             / dee_pkg::US_PER_S;
  localparam int TK_ERASE1 = (dee_pkg::ERASE_US_SEL1 * SUB_HZ + dee_pkg::US_PER_S - 1)
                             / dee_pkg::US_PER_S;
  localparam int TK_WRITE1 = (dee_pkg::WRITE_US_SEL1 * SUB_HZ + dee_pkg::US_PER_S - 1)
                             / dee_pkg::US_PER_S;
  localparam int CNT_W     = 16;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (MEM_BYTES <= 256 || MEM_BYTES > 512 || (MEM_BYTES & (MEM_BYTES - 1)) != 0
      || PAGE_BYTES < 2 || PAGE_BYTES > 256 || (PAGE_BYTES & (PAGE_BYTES - 1)) != 0)
  begin : g_chk_size
    $error("MEM_BYTES must be 512 and PAGE_BYTES a power of two from 2 to 256");
  end
  if (SUB_HZ < 1000 || TK_ERASE1 >= (1 << CNT_W) || TK_ERASE0 >= (1 << CNT_W))
  begin : g_chk_sub
    $error("SUB_HZ out of range for the cycle timer");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // page-mode advance: low bits stop at the last byte of the page
  function automatic logic [ADDR_W-1:0] page_advance(input logic [ADDR_W-1:0] a);
    logic [LOW_W-1:0] lo;
    lo = a[LOW_W-1:0];
    if (lo != {LOW_W{1'b1}})
    begin
      lo = lo + 1'b1;
    end
    page_advance = {a[ADDR_W-1:LOW_W], lo};
  endfunction

  function automatic logic hit(input dee_pkg::dee_req_s r, input logic [7:0] ofs);
    hit = (r.sector == dee_pkg::SECT_NVM) && (r.addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic ctl_sel = hit(i_req, dee_pkg::OFS_CONTROL) && i_req.indirect;
  wire logic al_sel  = hit(i_req, dee_pkg::OFS_ADDR_LOW);
  wire logic ah_sel  = hit(i_req, dee_pkg::OFS_ADDR_HIGH);
  wire logic dp_sel  = hit(i_req, dee_pkg::OFS_DATA_PORT);
  wire logic ctl_wr  = i_req.wr && ctl_sel;
  wire logic al_wr   = i_req.wr && al_sel;
  wire logic ah_wr   = i_req.wr && ah_sel;
  wire logic dp_wr   = i_req.wr && dp_sel;

  ////////////////////////////////////////////////////////////////////////////
  // state
  dee_pkg::dee_state_e      state_q;
  logic [CNT_W-1:0]         cnt_q;
  logic                     time_sel_q;
  logic                     mode_q;
  logic                     wipe_permit_q;
  logic                     wipe_permit_d;
  logic                     prog_permit_q;
  logic                     prog_permit_d;
  logic                     fetch_permit_q;
  logic [ADDR_W-1:0]        addr_q;
  logic [7:0]               data_q;
  logic                     page_full_q;
  logic [7:0]               mem      [MEM_BYTES];
  logic [7:0]               pbuf_q   [PAGE_BYTES];
  logic [PAGE_BYTES-1:0]    ptag_q;

  logic                     idle;
  logic                     go_erase;
  logic                     go_write;
  logic                     go_read;
  logic                     op_done;
  logic                     pbuf_clr;
  logic                     pbuf_load;
  logic [PAGE_W-1:0]        page;
  logic                     erasing;

  assign idle    = (state_q == dee_pkg::ST_IDLE);
  assign page    = addr_q[ADDR_W-1:LOW_W];
  assign erasing = (state_q == dee_pkg::ST_ERASE);

  // a start is taken only when its permit already stands, priority erase, write, read
  assign go_erase = idle && ctl_wr && i_req.wdata[dee_pkg::B_WIPE_TRIGGER]
                    && wipe_permit_q;
  assign go_write = idle && ctl_wr && i_req.wdata[dee_pkg::B_PROG_START]
                    && prog_permit_q && !go_erase;
  assign go_read  = idle && ctl_wr && i_req.wdata[dee_pkg::B_FETCH_TRIGGER]
                    && fetch_permit_q && !go_erase && !go_write;

  // reads end on system clocks, erase and write on subsidiary ticks
  assign op_done = !idle && (cnt_q == '0)
                   && ((state_q == dee_pkg::ST_READ) || i_sub_tick);

  assign o_busy = !idle;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= dee_pkg::ST_IDLE;
    end
    else if (idle)
    begin
      state_q <= go_erase ? dee_pkg::ST_ERASE
               : go_write ? dee_pkg::ST_WRITE
               : go_read ? dee_pkg::ST_READ : dee_pkg::ST_IDLE;
    end
    else if (op_done)
    begin
      state_q <= dee_pkg::ST_IDLE;
    end
  end

  // cycle timer
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= '0;
    end
    else if (go_erase)
    begin
      cnt_q <= time_sel_q ? CNT_W'(TK_ERASE1 - 1) : CNT_W'(TK_ERASE0 - 1);
    end
    else if (go_write)
    begin
      cnt_q <= time_sel_q ? CNT_W'(TK_WRITE1 - 1) : CNT_W'(TK_WRITE0 - 1);
    end
    else if (go_read)
    begin
      cnt_q <= CNT_W'(dee_pkg::READ_CLKS - 1);
    end
    else if (cnt_q != '0 && (state_q == dee_pkg::ST_READ || (!idle && i_sub_tick)))
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control fields
  always_comb
  begin
    wipe_permit_d = wipe_permit_q;
    prog_permit_d = prog_permit_q;
    if (ctl_wr)
    begin
      wipe_permit_d = i_req.wdata[dee_pkg::B_WIPE_PERMIT];
      prog_permit_d = i_req.wdata[dee_pkg::B_PROG_PERMIT];
    end
    else if (op_done && state_q == dee_pkg::ST_ERASE)
    begin
      wipe_permit_d = 1'b0;
    end
    else if (op_done && state_q == dee_pkg::ST_WRITE)
    begin
      prog_permit_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      time_sel_q     <= 1'b0;
      mode_q         <= 1'b0;
      wipe_permit_q  <= 1'b0;
      prog_permit_q  <= 1'b0;
      fetch_permit_q <= 1'b0;
    end
    else
    begin
      wipe_permit_q <= wipe_permit_d;
      prog_permit_q <= prog_permit_d;
      if (ctl_wr)
      begin
        time_sel_q     <= i_req.wdata[dee_pkg::B_TIME_SEL];
        mode_q         <= i_req.wdata[dee_pkg::B_MODE];
        fetch_permit_q <= i_req.wdata[dee_pkg::B_FETCH_PERMIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address: software loads, hardware advances in page mode
  assign pbuf_load = dp_wr && mode_q && !page_full_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      addr_q <= '0;
    end
    else if (al_wr)
    begin
      addr_q[7:0] <= i_req.wdata;
    end
    else if (ah_wr)
    begin
      addr_q[ADDR_W-1:8] <= i_req.wdata[ADDR_W-9:0];
    end
    else if ((op_done && state_q == dee_pkg::ST_READ && mode_q) || pbuf_load)
    begin
      addr_q <= page_advance(addr_q);
    end
  end

  // last slot of the page taken: later data writes are kept out of the page buffer
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      page_full_q <= 1'b0;
    end
    else if (al_wr || ah_wr || pbuf_clr)
    begin
      page_full_q <= 1'b0;
    end
    else if (pbuf_load && addr_q[LOW_W-1:0] == {LOW_W{1'b1}})
    begin
      page_full_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data port
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      data_q <= dee_pkg::RST_BYTE;
    end
    else if (op_done && state_q == dee_pkg::ST_READ)
    begin
      data_q <= mem[addr_q];
    end
    else if (dp_wr)
    begin
      data_q <= i_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page buffer, emptied at reset and whenever the wipe or prog permit falls
  assign pbuf_clr = (wipe_permit_q && !wipe_permit_d) || (prog_permit_q && !prog_permit_d);

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ptag_q <= '0;
    end
    else if (pbuf_clr)
    begin
      ptag_q <= '0;
    end
    else if (pbuf_load)
    begin
      ptag_q[addr_q[LOW_W-1:0]] <= 1'b1;
    end
  end

  // buffer bytes are only used where their tag is set, so they need no reset
  always_ff @(posedge i_clk_sys)
  begin
    if (pbuf_load)
    begin
      pbuf_q[addr_q[LOW_W-1:0]] <= i_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile array, kept across reset
  always_ff @(posedge i_clk_sys)
  begin
    if (op_done && state_q != dee_pkg::ST_READ && mode_q)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (ptag_q[i])
        begin
          mem[{page, LOW_W'(i)}] <= erasing ? dee_pkg::RST_BYTE : pbuf_q[i];
        end
      end
    end
    else if (op_done && state_q != dee_pkg::ST_READ)
    begin
      // whole-byte replace: the implied erase then program
      mem[addr_q] <= erasing ? dee_pkg::RST_BYTE : data_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read
  logic [7:0]               ctl_view;

  assign ctl_view = {time_sel_q, wipe_permit_q, state_q == dee_pkg::ST_ERASE, mode_q,
                     prog_permit_q, state_q == dee_pkg::ST_WRITE, fetch_permit_q,
                     state_q == dee_pkg::ST_READ};

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata <= dee_pkg::RST_BYTE;
    end
    else if (i_req.rd)
    begin
      o_rdata <= ctl_sel ? ctl_view
               : al_sel ? addr_q[7:0]
               : ah_sel ? 8'(addr_q[ADDR_W-1:8])
               : dp_sel ? data_q
               : dee_pkg::RD_UNMAPPED;
    end
  end

endmodule

`default_nettype wire

// *** tb/dee_ctrl_properties.sv ***
// checker for the data nonvolatile memory access controller
// assumes it is bound to dee_ctrl and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none
module dee_ctrl_properties #(
  parameter int MEM_BYTES  = 512,
  parameter int PAGE_BYTES = 16,
  parameter int SUB_HZ     = 32768
) (
  input wire logic              i_clk_sys,  // system clock
  input wire logic              i_rst_n,    // async reset, active low
  input wire logic              i_sub_tick, // subsidiary clock tick
  input wire dee_pkg::dee_req_s i_req,      // register access
  input wire logic [7:0]        o_rdata,    // read data
  input wire logic              o_busy      // cycle running
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////////
  logic       ctl_wr;
  logic       er_go;
  logic       pg_go;
  logic       rd_go;
  logic       busy_q;
  logic [7:0] ctl_q;
  logic [7:0] blen_q;
  logic [7:0] clr_q;

  // idle control write; shadow tracks permits written earlier
  assign ctl_wr = i_req.wr && i_req.indirect && i_req.sector == dee_pkg::SECT_NVM
                  && i_req.addr == dee_pkg::OFS_CONTROL && !o_busy;
  assign er_go = i_req.wdata[dee_pkg::B_WIPE_TRIGGER] && ctl_q[dee_pkg::B_WIPE_PERMIT];
  assign pg_go = i_req.wdata[dee_pkg::B_PROG_START] && ctl_q[dee_pkg::B_PROG_PERMIT];
  assign rd_go = i_req.wdata[dee_pkg::B_FETCH_TRIGGER] && ctl_q[dee_pkg::B_FETCH_PERMIT];

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctl_q  <= 8'h00;
      busy_q <= 1'b0;
      blen_q <= 8'h00;
      clr_q  <= 8'h00;
    end
    else
    begin
      busy_q <= o_busy;
      blen_q <= !o_busy ? 8'h00 : (blen_q == 8'hff ? blen_q : blen_q + 8'h01);
      // only the start of the cycle that ran falls at its end, with its permit for erase and write
      if (ctl_wr)
      begin
        ctl_q <= i_req.wdata;
        clr_q <= er_go ? 8'h60 : (pg_go ? 8'h0c : 8'h01);
      end
      else if (busy_q && !o_busy)
        ctl_q <= ctl_q & ~clr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  rdata_hold_a: assert property ($changed(o_rdata) |-> $past(i_req.rd))
    else $error("read data moved without a read");
  unmapped_rd_a: assert property (i_req.rd && i_req.sector != dee_pkg::SECT_NVM
    |=> o_rdata == 8'h00) else $error("unmapped read not zero");
  ctl_direct_a: assert property (i_req.rd && !i_req.indirect && i_req.sector == dee_pkg::SECT_NVM
    && i_req.addr == dee_pkg::OFS_CONTROL |=> o_rdata == 8'h00)
    else $error("direct control read answered");
  addr_high_a: assert property (i_req.rd && i_req.sector == dee_pkg::SECT_NVM
    && i_req.addr == dee_pkg::OFS_ADDR_HIGH |=> o_rdata[7:1] == 7'h00)
    else $error("address high upper bits set");
  start_go_a: assert property (ctl_wr && (er_go || pg_go || rd_go) |=> o_busy)
    else $error("permitted start ignored");
  start_refused_a: assert property (ctl_wr && !(er_go || pg_go || rd_go) |=> !o_busy)
    else $error("cycle started without permit");
  read_length_a: assert property (ctl_wr && rd_go && !er_go && !pg_go
    |=> o_busy [*4] ##1 !o_busy) else $error("read cycle length wrong");
  long_on_tick_a: assert property ($fell(o_busy) && $past(blen_q) > 8'd4
    |-> $past(i_sub_tick)) else $error("timed cycle ended off a tick");
endmodule

bind dee_ctrl dee_ctrl_properties #(
  .MEM_BYTES  (MEM_BYTES),
  .PAGE_BYTES (PAGE_BYTES),
  .SUB_HZ     (SUB_HZ)
) u_props (
  .i_clk_sys  (i_clk_sys),
  .i_rst_n    (i_rst_n),
  .i_sub_tick (i_sub_tick),
  .i_req      (i_req),
  .o_rdata    (o_rdata),
  .o_busy     (o_busy)
);
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the data nonvolatile memory access controller
// assumes dee_pkg and dee_ctrl are compiled first; ticks come every 4 clocks
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int SUB  = 10000;
  localparam int TMAX = 20000;
  localparam logic [3:0] S1 = dee_pkg::SECT_NVM;
  localparam logic [7:0] CT = dee_pkg::OFS_CONTROL;
  localparam logic [7:0] AL = dee_pkg::OFS_ADDR_LOW;
  localparam logic [7:0] AH = dee_pkg::OFS_ADDR_HIGH;
  localparam logic [7:0] DP = dee_pkg::OFS_DATA_PORT;

  logic              i_clk_sys;
  logic              i_rst_n;
  logic              i_sub_tick;
  dee_pkg::dee_req_s i_req;
  logic [7:0]        o_rdata;
  logic              o_busy;
  int                n_errors;
  int                checks;
  int                n_tick;
  int                n_cyc;

  dee_ctrl #(.MEM_BYTES(512), .PAGE_BYTES(16), .SUB_HZ(SUB)) DUT (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_sub_tick (i_sub_tick),
    .i_req      (i_req),
    .o_rdata    (o_rdata),
    .o_busy     (o_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // tick source and hang guard
  always @(negedge i_clk_sys)
  begin
    n_cyc <= n_cyc + 1;
    i_sub_tick <= (n_cyc % 4 == 3);
    if (n_cyc == TMAX)
    begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: cycle limit reached", $time);
      give_verdict();
    end
  end

  always @(posedge i_clk_sys)
    if (o_busy === 1'b1 && i_sub_tick === 1'b1)
      n_tick <= n_tick + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_req = '{wr: 1'b1, rd: 1'b0, indirect: 1'b1, sector: S1, addr: ofs, wdata: d};
    @(negedge i_clk_sys);
    i_req = '0;
  endtask

  task automatic rd_reg(input logic [3:0] sec, input logic [7:0] ofs, input logic ind,
                        output logic [7:0] q);
    @(negedge i_clk_sys);
    i_req = '{wr: 1'b0, rd: 1'b1, indirect: ind, sector: sec, addr: ofs, wdata: 8'h00};
    @(negedge i_clk_sys);
    i_req = '0;
    q = o_rdata;
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (o_busy !== 1'b0 && k < 5000)
    begin
      @(negedge i_clk_sys);
      k++;
    end
    if (k == 5000)
    begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: busy never fell", $time);
    end
  endtask

  function automatic int tk(input int us);
    return (us * SUB + dee_pkg::US_PER_S - 1) / dee_pkg::US_PER_S;
  endfunction

  task automatic set_addr(input logic [8:0] a);
    wr_reg(AH, {7'h00, a[8]});
    wr_reg(AL, a[7:0]);
  endtask

  // permit, then start, then count ticks of the timed cycle
  task automatic op(input logic [7:0] p, input logic [7:0] s, input int ticks);
    wr_reg(CT, p);
    n_tick = 0;
    wr_reg(CT, s);
    wait_idle();
    check8(n_tick[7:0], ticks[7:0]);
  endtask

  task automatic rd_byte(input logic [7:0] m, output logic [7:0] q);
    wr_reg(CT, m | 8'h01);
    wait_idle();
    rd_reg(S1, DP, 1'b1, q);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] q;
    for (int i = 0; i < 4; i++)
    begin
      rd_reg(S1, CT + i[7:0], 1'b1, q);
      check8(q, dee_pkg::RST_BYTE);
    end
    wr_reg(AH, 8'hff);
    rd_reg(S1, AH, 1'b1, q);
    check8(q, 8'h01);
    wr_reg(CT, 8'h10);
    rd_reg(S1, CT, 1'b0, q);
    check8(q, dee_pkg::RD_UNMAPPED);
    rd_reg(S1, CT, 1'b1, q);
    check8(q, 8'h10);
    rd_reg(4'h2, DP, 1'b1, q);
    check8(q, dee_pkg::RD_UNMAPPED);
    wr_reg(CT, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_refuse;
    logic [7:0] s [3] = '{8'h20, 8'h04, 8'h01};
    logic [7:0] q;
    foreach (s[i])
    begin
      wr_reg(CT, s[i]);
      check8({7'h00, o_busy}, 8'h00);
      rd_reg(S1, CT, 1'b1, q);
      check8(q, 8'h00);
    end
    $display("test refuse done");
  endtask

  task automatic t_byte;
    logic [8:0] ad [3] = '{9'h1a5, 9'h0a5, 9'h1a5};
    logic [7:0] dt [3] = '{8'h5c, 8'h33, 8'hc3};
    logic [7:0] p;
    logic [7:0] q;
    for (int i = 0; i < 3; i++)
    begin
      p = (i == 1) ? 8'h88 : 8'h08;
      set_addr(ad[i]);
      wr_reg(DP, dt[i]);
      op(p, p | 8'h04, tk(i == 1 ? dee_pkg::WRITE_US_SEL1 : dee_pkg::WRITE_US_SEL0));
      rd_reg(S1, CT, 1'b1, q);
      check8(q, p & 8'h80);
    end
    wr_reg(CT, 8'h02);
    set_addr(9'h1a5);
    rd_byte(8'h02, q);
    check8(q, 8'hc3);
    rd_reg(S1, CT, 1'b1, q);
    check8(q, 8'h02);
    set_addr(9'h0a5);
    rd_byte(8'h02, q);
    check8(q, 8'h33);
    repeat (20) @(negedge i_clk_sys);
    rd_reg(S1, DP, 1'b1, q);
    check8(q, 8'h33);
    $display("test byte done");
  endtask

  task automatic t_page;
    logic [7:0] q;
    wr_reg(CT, 8'h10);
    set_addr(9'h0f0);
    for (int i = 0; i < 17; i++)
      wr_reg(DP, 8'h80 + i[7:0]);
    rd_reg(S1, AL, 1'b1, q);
    check8(q, 8'hff);
    op(8'h18, 8'h1c, tk(dee_pkg::WRITE_US_SEL0));
    wr_reg(CT, 8'h12);
    set_addr(9'h0f0);
    for (int i = 0; i < 17; i++)
    begin
      rd_byte(8'h12, q);
      check8(q, 8'h80 + ((i > 15) ? 8'h0f : i[7:0]));
    end
    rd_reg(S1, AH, 1'b1, q);
    check8(q, 8'h00);
    $display("test page done");
  endtask

  task automatic t_erase;
    logic [7:0] q;
    wr_reg(CT, 8'h00);
    set_addr(9'h0a5);
    op(8'h40, 8'h60, tk(dee_pkg::ERASE_US_SEL0));
    wr_reg(CT, 8'h02);
    rd_byte(8'h02, q);
    check8(q, 8'h00);
    wr_reg(CT, 8'h10);
    set_addr(9'h0f0);
    wr_reg(DP, 8'h00);
    wr_reg(DP, 8'h00);
    op(8'hd0, 8'hf0, tk(dee_pkg::ERASE_US_SEL1));
    rd_reg(S1, CT, 1'b1, q);
    check8(q, 8'h90);
    wr_reg(CT, 8'h12);
    set_addr(9'h0f0);
    for (int i = 0; i < 3; i++)
    begin
      rd_byte(8'h12, q);
      check8(q, (i < 2) ? 8'h00 : 8'h82);
    end
    $display("test erase done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_rst_n    = 1'b0;
    i_req      = '0;
    i_sub_tick = 1'b0;
    n_errors   = 0;
    checks     = 0;
    n_tick     = 0;
    n_cyc      = 0;
    repeat (12) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    t_regs();
    t_refuse();
    t_byte();
    t_page();
    t_erase();
    give_verdict();
  end
endmodule
`default_nettype wire
